/* File: inc/csp_pkg.sv */
// Constants for the core status, port and power control register bank
// Summary of operation
// - Carry set on add carry-out or subtract no-borrow, else cleared
// - Half-carry set on carry out of bit 3, or no borrow into it
// - Zero flag follows whether the arithmetic or logic result is zero
// - Power-down flag set by reset and watchdog-clear, cleared by sleep
// - Timeout flag set by reset, watchdog-clear or sleep; cleared by timeout
// - Two-bit bank select field picks one of four data memory banks
// - Pointer low seven bits pick a register; top bit is plain storage
// - Accesses to the indirect location go to the pointed register
// - Port A reads pin, or latch for outputs when read option says so
// - Writing port A loads its eight-bit output latch
// - Port B low six bits read like port A; top two are storage
// - Power control bit 7 enables the watchdog; resets to one
// - Power control bit 5 enables low-voltage detect; resets to zero
// - Power control bit 3 enables low-voltage reset; resets to one
// - Power control bit 4 is active-low pin A5 pull-up; resets to one
// - Six wake bits enable port B pin wake-up; reset to one
// - PC high buffer holds three write-only bits for PC 10:8
// - PC bits 10:8 change only through the high buffer
// - Writing one to buffer bit 6 pulses the crystal boost stop
// - Pull-low bits 3:0 are active-low port A pull-downs, reset one
// - Pull-low bits 7:4 are active-low port B pull-downs, reset one
// - Six active-low port B pull-up bits, reset to one
package csp_pkg;
  localparam int IDX_W = 10;
  // -------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // -------------------------------------------------------------
  localparam logic [9:0] IDX_IND = 10'h000;
  localparam logic [9:0] IDX_STATUS = 10'h003;
  localparam logic [9:0] IDX_PTR = 10'h004;
  localparam logic [9:0] IDX_PA = 10'h005;
  localparam logic [9:0] IDX_PB = 10'h006;
  localparam logic [9:0] IDX_POWER_CONTROL = 10'h008;
  localparam logic [9:0] IDX_WAKE = 10'h009;
  localparam logic [9:0] IDX_PCH = 10'h00A;
  localparam logic [9:0] IDX_PULLDN = 10'h00B;
  localparam logic [9:0] IDX_PULLUP = 10'h00C;
  // -------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_BK = 6;
  localparam int PW_WDT = 7;
  localparam int PW_LVD = 5;
  localparam int PW_A5 = 4;
  localparam int PW_LVR = 3;
  localparam int PCH_STOP = 6;
  localparam int PD_B_LO = 4;
  // -------------------------------------------------------------
  // Reset values and implemented-bit masks
  // -------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h98;
  localparam logic [5:0] RST_SIX = 6'h3F;
  localparam logic [2:0] RST_PCH = 3'h0;
  localparam logic [7:0] RST_PULLDN = 8'hFF;
  localparam logic [7:0] NIB_MAX = 8'h0F;
  // -------------------------------------------------------------
  // Arithmetic operation codes from the core
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    CSP_OP_NONE = 2'h0,
    CSP_OP_ADD = 2'h1,
    CSP_OP_SUB = 2'h3,
    CSP_OP_LOGIC = 2'h2
  } csp_alu_op_t;
endpackage : csp_pkg

/* File: hw/csp_regs.sv */
// Core status, port and power control register bank with APB access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module csp_regs (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core arithmetic and events
  input wire csp_pkg::csp_alu_op_t alu_op_i,
  input wire logic [7:0] alu_a_i,
  input wire logic [7:0] alu_b_i,
  output logic [7:0] alu_result_o,
  input wire logic clrwdt_i,
  input wire logic sleep_i,
  input wire logic wdt_timeout_i,
  // Pins and port configuration
  input wire logic [7:0] first_port_pin_i,
  input wire logic [5:0] second_port_pin_i,
  input wire logic [7:0] first_port_is_input_i,
  input wire logic [5:0] second_port_is_input_i,
  input wire logic read_option_setting_i,
  // Control outputs
  output logic [1:0] bank_select_o,
  output logic [6:0] indirect_pointer_o,
  output logic [7:0] first_port_latch_o,
  output logic [5:0] second_port_latch_o,
  output logic watchdog_on_o,
  output logic low_voltage_detect_on_o,
  output logic low_voltage_reset_on_o,
  output logic pin_a5_pull_up_n_o,
  output logic [5:0] port_b_wake_bit_o,
  output logic [2:0] pc_high_buffer_o,
  output logic crystal_boost_stop_o,
  output logic [3:0] port_a_pull_down_n_o,
  output logic [3:0] port_b_pull_down_n_o,
  output logic [5:0] port_b_pull_up_n_o
);

  // -------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------
  function automatic logic is_mapped(
    input logic [csp_pkg::IDX_W-1:0] idx
  );
    is_mapped = (idx == csp_pkg::IDX_STATUS) ||
                (idx == csp_pkg::IDX_PTR) ||
                (idx == csp_pkg::IDX_PA) ||
                (idx == csp_pkg::IDX_PB) ||
                (idx == csp_pkg::IDX_POWER_CONTROL) ||
                (idx == csp_pkg::IDX_WAKE) ||
                (idx == csp_pkg::IDX_PCH) ||
                (idx == csp_pkg::IDX_PULLDN) ||
                (idx == csp_pkg::IDX_PULLUP);
  endfunction : is_mapped

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] ptr_reg;
  logic [7:0] pa_reg;
  logic [7:0] pb_reg;
  logic [7:0] power_control_reg;
  logic [5:0] wake_reg;
  logic [2:0] pch_reg;
  logic stop_reg;
  logic [7:0] pulldn_reg;
  logic [5:0] pullup_reg;
  logic [7:0] alu_res_reg;
  logic [31:0] rdata_reg;
  logic [7:0] pa_s1_reg;
  logic [7:0] pa_s2_reg;
  logic [5:0] pb_s1_reg;
  logic [5:0] pb_s2_reg;

  // -------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------
  wire [csp_pkg::IDX_W-1:0] req_idx = paddr_i[11:2];
  wire [csp_pkg::IDX_W-1:0] ptr_idx = {3'h0, ptr_reg[6:0]};
  wire [csp_pkg::IDX_W-1:0] eff_idx =
    (req_idx == csp_pkg::IDX_IND) ? ptr_idx : req_idx;
  wire hit = is_mapped(eff_idx);
  wire setup_ph = psel_i & ~penable_i;
  wire access_ph = psel_i & penable_i;
  wire wr_en = access_ph & pwrite_i & hit & pstrb_i[0];
  wire [7:0] wd = pwdata_i[7:0];
  wire wr_status = wr_en & (eff_idx == csp_pkg::IDX_STATUS);
  wire wr_ptr = wr_en & (eff_idx == csp_pkg::IDX_PTR);
  wire wr_pa = wr_en & (eff_idx == csp_pkg::IDX_PA);
  wire wr_pb = wr_en & (eff_idx == csp_pkg::IDX_PB);
  wire wr_power_control = wr_en & (eff_idx == csp_pkg::IDX_POWER_CONTROL);
  wire wr_wake = wr_en & (eff_idx == csp_pkg::IDX_WAKE);
  wire wr_pch = wr_en & (eff_idx == csp_pkg::IDX_PCH);
  wire wr_pulldn = wr_en & (eff_idx == csp_pkg::IDX_PULLDN);
  wire wr_pullup = wr_en & (eff_idx == csp_pkg::IDX_PULLUP);

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pa_s1_reg <= csp_pkg::RST_ZERO;
      pa_s2_reg <= csp_pkg::RST_ZERO;
      pb_s1_reg <= '0;
      pb_s2_reg <= '0;
    end else begin
      pa_s1_reg <= first_port_pin_i;
      pa_s2_reg <= pa_s1_reg;
      pb_s1_reg <= second_port_pin_i;
      pb_s2_reg <= pb_s1_reg;
    end
  end

  // -------------------------------------------------------------
  // Port readback
  // -------------------------------------------------------------
  // pin or latch per bit
  wire [7:0] pa_sel = ~first_port_is_input_i &
                      {8{read_option_setting_i}};
  wire [7:0] pa_rd = (pa_reg & pa_sel) | (pa_s2_reg & ~pa_sel);
  wire [5:0] pb_sel = ~second_port_is_input_i &
                      {6{read_option_setting_i}};
  wire [5:0] pb_lo = (pb_reg[5:0] & pb_sel) | (pb_s2_reg & ~pb_sel);
  wire [7:0] pb_rd = {pb_reg[7:6], pb_lo};

  // -------------------------------------------------------------
  // Arithmetic
  // -------------------------------------------------------------
  wire is_sub = (alu_op_i == csp_pkg::CSP_OP_SUB);
  wire is_arith = is_sub | (alu_op_i == csp_pkg::CSP_OP_ADD);
  // Subtraction as a + ~b + 1, so carry-out means no borrow
  wire [7:0] b_eff = is_sub ? ~alu_b_i : alu_b_i;
  wire [8:0] sum = {1'b0, alu_a_i} + {1'b0, b_eff} +
                   {8'h00, is_sub};
  wire [4:0] nib = {1'b0, alu_a_i[3:0]} + {1'b0, b_eff[3:0]} +
                   {4'h0, is_sub};
  wire [7:0] result = is_arith ? sum[7:0] : alu_a_i;
  wire alu_any = (alu_op_i != csp_pkg::CSP_OP_NONE);

  // -------------------------------------------------------------
  // Status next value
  // -------------------------------------------------------------
  // Hardware events are applied after the software write so they win
  always_comb begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = wd;
    end
    if (is_arith) begin
      status_next[csp_pkg::ST_C] = sum[8];
      status_next[csp_pkg::ST_DC] = nib[4];
    end
    if (alu_any) begin
      status_next[csp_pkg::ST_Z] = (result == csp_pkg::RST_ZERO);
    end
    if (sleep_i) begin
      status_next[csp_pkg::ST_PD] = 1'b0;
    end
    if (clrwdt_i) begin
      status_next[csp_pkg::ST_PD] = 1'b1;
    end
    if (wdt_timeout_i) begin
      status_next[csp_pkg::ST_TO] = 1'b0;
    end
    if (clrwdt_i | sleep_i) begin
      status_next[csp_pkg::ST_TO] = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      status_reg <= csp_pkg::RST_STATUS;
      alu_res_reg <= csp_pkg::RST_ZERO;
    end else begin
      status_reg <= status_next;
      if (alu_any) begin
        alu_res_reg <= result;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ptr_reg <= csp_pkg::RST_ZERO;
      pa_reg <= csp_pkg::RST_ZERO;
      pb_reg <= csp_pkg::RST_ZERO;
    end else begin
      if (wr_ptr) begin
        ptr_reg <= wd;
      end
      if (wr_pa) begin
        pa_reg <= wd;
      end
      if (wr_pb) begin
        pb_reg <= wd;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      power_control_reg <= csp_pkg::RST_POWER_CONTROL;
      wake_reg <= csp_pkg::RST_SIX;
      pullup_reg <= csp_pkg::RST_SIX;
      pulldn_reg <= csp_pkg::RST_PULLDN;
    end else begin
      if (wr_power_control) begin
        power_control_reg <= wd;
      end
      if (wr_wake) begin
        wake_reg <= wd[5:0];
      end
      if (wr_pullup) begin
        pullup_reg <= wd[5:0];
      end
      if (wr_pulldn) begin
        pulldn_reg <= wd;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pch_reg <= csp_pkg::RST_PCH;
      stop_reg <= 1'b0;
    end else begin
      if (wr_pch) begin
        pch_reg <= wd[2:0];
      end
      stop_reg <= wr_pch & wd[csp_pkg::PCH_STOP];
    end
  end

  // -------------------------------------------------------------
  // Read mux
  // -------------------------------------------------------------
  logic [7:0] rd_val;
  // write-only and missing bits read zero
  always_comb begin
    rd_val = csp_pkg::RST_ZERO;
    if (eff_idx == csp_pkg::IDX_STATUS) begin
      rd_val = status_reg;
    end else if (eff_idx == csp_pkg::IDX_PTR) begin
      rd_val = ptr_reg;
    end else if (eff_idx == csp_pkg::IDX_PA) begin
      rd_val = pa_rd;
    end else if (eff_idx == csp_pkg::IDX_PB) begin
      rd_val = pb_rd;
    end else if (eff_idx == csp_pkg::IDX_POWER_CONTROL) begin
      rd_val = power_control_reg;
    end else if (eff_idx == csp_pkg::IDX_WAKE) begin
      rd_val = {2'h0, wake_reg};
    end else if (eff_idx == csp_pkg::IDX_PULLDN) begin
      rd_val = pulldn_reg;
    end else if (eff_idx == csp_pkg::IDX_PULLUP) begin
      rd_val = {2'h0, pullup_reg};
    end
  end

  // Read data is captured in the setup cycle; a zero-wait access
  // then returns it without a combinational path to prdata.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= '0;
    end else if (setup_ph & ~pwrite_i) begin
      rdata_reg <= {24'h000000, rd_val};
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  assign prdata_o = rdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph & ~hit;
  assign alu_result_o = alu_res_reg;
  assign bank_select_o = status_reg[csp_pkg::ST_BK +: 2];
  assign indirect_pointer_o = ptr_reg[6:0];
  assign first_port_latch_o = pa_reg;
  assign second_port_latch_o = pb_reg[5:0];
  assign watchdog_on_o = power_control_reg[csp_pkg::PW_WDT];
  assign low_voltage_detect_on_o = power_control_reg[csp_pkg::PW_LVD];
  assign low_voltage_reset_on_o = power_control_reg[csp_pkg::PW_LVR];
  assign pin_a5_pull_up_n_o = power_control_reg[csp_pkg::PW_A5];
  assign port_b_wake_bit_o = wake_reg;
  // PC high bits only via the buffer
  assign pc_high_buffer_o = pch_reg;
  assign crystal_boost_stop_o = stop_reg;
  assign port_a_pull_down_n_o = pulldn_reg[3:0];
  assign port_b_pull_down_n_o = pulldn_reg[csp_pkg::PD_B_LO +: 4];
  assign port_b_pull_up_n_o = pullup_reg;

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  property p_carry_add;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (alu_op_i == csp_pkg::CSP_OP_ADD) |=> status_reg[csp_pkg::ST_C] ==
      (({1'b0, $past(alu_a_i)} + {1'b0, $past(alu_b_i)}) > 9'h0FF);
  endproperty
  a_carry_add: assert property (p_carry_add)
    else $error("carry wrong after add");

  property p_half_sub;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (alu_op_i == csp_pkg::CSP_OP_SUB) |=> status_reg[csp_pkg::ST_DC] ==
      ($past(alu_a_i[3:0]) >= $past(alu_b_i[3:0]));
  endproperty
  a_half_sub: assert property (p_half_sub)
    else $error("half carry wrong after subtract");

  property p_zero;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (alu_op_i != csp_pkg::CSP_OP_NONE) |=>
      status_reg[csp_pkg::ST_Z] == (alu_result_o == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with result");

  property p_pd_sleep;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (sleep_i && !clrwdt_i) |=>
      !status_reg[csp_pkg::ST_PD] && status_reg[csp_pkg::ST_TO];
  endproperty
  a_pd_sleep: assert property (p_pd_sleep)
    else $error("sleep did not set power-down state");

  property p_to_timeout;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (wdt_timeout_i && !clrwdt_i && !sleep_i) |=>
      !status_reg[csp_pkg::ST_TO];
  endproperty
  a_to_timeout: assert property (p_to_timeout)
    else $error("timeout did not clear flag");

  property p_indirect;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (setup_ph && !pwrite_i && req_idx == csp_pkg::IDX_IND &&
     ptr_idx == csp_pkg::IDX_POWER_CONTROL) |=>
      prdata_o == {24'h000000, $past(power_control_reg)};
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect read not redirected");

  property p_pa_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_pa |=> first_port_latch_o == $past(pwdata_i[7:0]);
  endproperty
  a_pa_write: assert property (p_pa_write)
    else $error("port A latch not loaded");

  property p_power_control_reset;
    @(posedge ref_clk_i)
    sys_rst_i |=> watchdog_on_o && low_voltage_reset_on_o &&
      pin_a5_pull_up_n_o && !low_voltage_detect_on_o;
  endproperty
  a_power_control_reset: assert property (p_power_control_reset)
    else $error("power control reset value wrong");

  property p_stop_pulse;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_pch && pwdata_i[csp_pkg::PCH_STOP]) ##1 !wr_pch |->
      crystal_boost_stop_o ##1 !crystal_boost_stop_o;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("boost stop strobe longer than a cycle");

  property p_wo_read;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (setup_ph && !pwrite_i && eff_idx == csp_pkg::IDX_PCH) |=>
      prdata_o == 32'h00000000;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only register read non-zero");

endmodule : csp_regs

/* File: dv/csp_pin_model.sv */
// Pin-side model of one port as seen by the register bank
`timescale 1ns/1ps
module csp_pin_model #(
  parameter int W = 8
) (
  // Port configuration and outside drive
  input wire logic [W-1:0] latch_i,
  input wire logic [W-1:0] is_input_i,
  input wire logic [W-1:0] ext_i,
  input wire logic fight_i,
  // Pin levels
  output logic [W-1:0] pin_o
);
  logic [W-1:0] drive;
  // An overdriven output pin reads opposite to its latch, so that a pin
  // read and a latch read can be told apart
  assign drive = fight_i ? ~latch_i : latch_i;
  assign pin_o = (is_input_i & ext_i) | (~is_input_i & drive);
endmodule : csp_pin_model

/* File: dv/csp_regs_test.sv */
// Self-checking testbench of the status, port and power register bank
`timescale 1ns/1ps
module csp_regs_test;
  logic ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [3:0] pstrb_i;
  logic pready_o, pslverr_o, clrwdt_i, sleep_i, wdt_timeout_i;
  csp_pkg::csp_alu_op_t alu_op_i;
  logic [7:0] alu_a_i, alu_b_i, alu_result_o, first_port_pin_i;
  logic [7:0] first_port_is_input_i, first_port_latch_o, pa_ext;
  logic [5:0] second_port_pin_i, second_port_is_input_i, pb_ext;
  logic [5:0] second_port_latch_o, port_b_wake_bit_o, port_b_pull_up_n_o;
  logic read_option_setting_i, fight, watchdog_on_o;
  logic low_voltage_detect_on_o, low_voltage_reset_on_o;
  logic pin_a5_pull_up_n_o, crystal_boost_stop_o;
  logic [1:0] bank_select_o;
  logic [6:0] indirect_pointer_o;
  logic [2:0] pc_high_buffer_o;
  logic [3:0] port_a_pull_down_n_o, port_b_pull_down_n_o;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  csp_regs i_csp_regs (.*);
  csp_pin_model #(.W(8)) i_csp_pin_model_a (.latch_i(first_port_latch_o),
    .is_input_i(first_port_is_input_i), .ext_i(pa_ext), .fight_i(fight),
    .pin_o(first_port_pin_i));
  csp_pin_model #(.W(6)) i_csp_pin_model_b (.latch_i(second_port_latch_o),
    .is_input_i(second_port_is_input_i), .ext_i(pb_ext), .fight_i(fight),
    .pin_o(second_port_pin_i));

  // ----------------------------------------------------------------
  // Clock, time-zero values and hang guard
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {sys_rst_i, psel_i, penable_i, pwrite_i, clrwdt_i} = 5'h10;
    {sleep_i, wdt_timeout_i, read_option_setting_i, fight} = 4'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    pstrb_i = 4'hF;
    alu_op_i = csp_pkg::CSP_OP_NONE;
    {alu_a_i, alu_b_i, pa_ext, first_port_is_input_i} = 32'h00000000;
    {pb_ext, second_port_is_input_i} = 12'h000;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= {24'h000000, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask : wr

  task automatic rchk(input string what, input logic [9:0] idx,
                      input logic [7:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    chk(what, rd, {24'h000000, exp});
    chk("slave error", err, 1'b0);
  endtask : rchk

  task automatic do_reset(input int n);
    sys_rst_i <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("status", csp_pkg::IDX_STATUS, 8'h18);
    rchk("pointer", csp_pkg::IDX_PTR, 8'h00);
    rchk("power_control", csp_pkg::IDX_POWER_CONTROL, 8'h98);
    rchk("wake", csp_pkg::IDX_WAKE, 8'h3F);
    rchk("pch", csp_pkg::IDX_PCH, 8'h00);
    rchk("pull low", csp_pkg::IDX_PULLDN, 8'hFF);
    rchk("pull up", csp_pkg::IDX_PULLUP, 8'h3F);
    chk("enables", {pc_high_buffer_o, crystal_boost_stop_o, watchdog_on_o,
      low_voltage_detect_on_o, low_voltage_reset_on_o,
      pin_a5_pull_up_n_o}, 8'h0B);
    chk("pulls", {port_a_pull_down_n_o, port_b_pull_down_n_o,
      port_b_pull_up_n_o, port_b_wake_bit_o}, 20'hFFFFF);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_regs();
    logic [31:0] rd;
    logic err;
    wr(csp_pkg::IDX_POWER_CONTROL, 8'h67);
    pstrb_i <= 4'h0;
    #1 chk("power_control bits", {watchdog_on_o, low_voltage_detect_on_o,
      low_voltage_reset_on_o, pin_a5_pull_up_n_o}, 4'h4);
    wr(csp_pkg::IDX_POWER_CONTROL, 8'h98);
    pstrb_i <= 4'hF;
    rchk("power_control", csp_pkg::IDX_POWER_CONTROL, 8'h67);
    wr(csp_pkg::IDX_WAKE, 8'hD5);
    rchk("wake", csp_pkg::IDX_WAKE, 8'h15);
    chk("wake out", port_b_wake_bit_o, 6'h15);
    wr(csp_pkg::IDX_PULLUP, 8'hEA);
    rchk("pull up", csp_pkg::IDX_PULLUP, 8'h2A);
    chk("pull up out", port_b_pull_up_n_o, 6'h2A);
    wr(csp_pkg::IDX_PULLDN, 8'h5A);
    rchk("pull low", csp_pkg::IDX_PULLDN, 8'h5A);
    chk("pull low out", {port_a_pull_down_n_o, port_b_pull_down_n_o},
      8'hA5);
    wr(csp_pkg::IDX_PCH, 8'h45);
    #1 chk("stop pulse", {crystal_boost_stop_o, pc_high_buffer_o},
      4'hD);
    @(posedge ref_clk_i);
    #1 chk("stop ends", crystal_boost_stop_o, 1'b0);
    rchk("pch", csp_pkg::IDX_PCH, 8'h00);
    wr(csp_pkg::IDX_PCH, 8'h02);
    #1 chk("pch only", {crystal_boost_stop_o, pc_high_buffer_o},
      4'h2);
    apb(1'b0, 10'h007, 8'h00, rd, err);
    chk("unmapped read", rd, 32'h00000000);
    chk("unmapped error", err, 1'b1);
    for (int b = 0; b < 4; b++) begin
      wr(csp_pkg::IDX_STATUS, {b[1:0], 6'h38});
      #1 chk("bank", bank_select_o, b[1:0]);
      rchk("status", csp_pkg::IDX_STATUS, {b[1:0], 6'h38});
    end
    wr(csp_pkg::IDX_STATUS, 8'h18);
    $display("test register access done");
  endtask : t_regs

  task automatic t_pointer();
    logic [31:0] rd;
    logic err;
    wr(csp_pkg::IDX_PTR, 8'h83);
    rchk("pointer", csp_pkg::IDX_PTR, 8'h83);
    chk("pointer out", indirect_pointer_o, 7'h03);
    rchk("indirect read", csp_pkg::IDX_IND, 8'h18);
    wr(csp_pkg::IDX_PTR, 8'h08);
    wr(csp_pkg::IDX_IND, 8'h11);
    rchk("indirect power_control", csp_pkg::IDX_IND, 8'h11);
    rchk("indirect write", csp_pkg::IDX_POWER_CONTROL, 8'h11);
    wr(csp_pkg::IDX_PTR, 8'h07);
    apb(1'b0, csp_pkg::IDX_IND, 8'h00, rd, err);
    chk("indirect unmapped", rd, 32'h00000000);
    chk("indirect error", err, 1'b1);
    $display("test indirect access done");
  endtask : t_pointer

  task automatic t_ports();
    logic [7:0] ea;
    logic [5:0] eb;
    wr(csp_pkg::IDX_PA, 8'hA5);
    wr(csp_pkg::IDX_PB, 8'hE5);
    pa_ext <= 8'h3C;
    pb_ext <= 6'h2A;
    fight <= 1'b1;
    first_port_is_input_i <= 8'h0F;
    second_port_is_input_i <= 6'h07;
    #1 chk("latches", {first_port_latch_o, second_port_latch_o},
      14'h2965);
    for (int o = 0; o < 2; o++) begin
      @(posedge ref_clk_i);
      read_option_setting_i <= o[0];
      repeat (4) @(posedge ref_clk_i);
      ea = 8'h0C | (o[0] ? 8'hA0 : 8'h50);
      eb = 6'h02 | (o[0] ? 6'h20 : 6'h18);
      rchk("port a", csp_pkg::IDX_PA, ea);
      rchk("port b", csp_pkg::IDX_PB, {2'b11, eb});
    end
    $display("test port readback done");
  endtask : t_ports

  task automatic t_alu();
    csp_pkg::csp_alu_op_t op [7] = '{csp_pkg::CSP_OP_ADD,
      csp_pkg::CSP_OP_ADD, csp_pkg::CSP_OP_SUB, csp_pkg::CSP_OP_SUB,
      csp_pkg::CSP_OP_SUB, csp_pkg::CSP_OP_LOGIC, csp_pkg::CSP_OP_LOGIC};
    logic [7:0] av [7] = '{8'h0F, 8'hF0, 8'h10, 8'h01, 8'h05, 8'h00, 8'h40};
    logic [7:0] bv [7] = '{8'h01, 8'h10, 8'h01, 8'h02, 8'h05, 8'h00, 8'h00};
    logic [8:0] sum;
    logic [4:0] hn;
    logic [2:0] fl;
    logic sub;
    for (int k = 0; k < 7; k++) begin
      sub = (op[k] == csp_pkg::CSP_OP_SUB);
      sum = {1'b0, av[k]} + {1'b0, sub ? ~bv[k] : bv[k]} + {8'h00, sub};
      hn = {1'b0, av[k][3:0]} + {1'b0, sub ? ~bv[k][3:0] : bv[k][3:0]}
        + {4'h0, sub};
      if (op[k] == csp_pkg::CSP_OP_LOGIC) begin
        sum = {1'b0, av[k]};
        hn = {fl[1], 4'h0};
        sum[8] = fl[0];
      end
      fl = {sum[7:0] == 8'h00, hn[4], sum[8]};
      @(posedge ref_clk_i);
      alu_op_i <= op[k];
      alu_a_i <= av[k];
      alu_b_i <= bv[k];
      @(posedge ref_clk_i);
      alu_op_i <= csp_pkg::CSP_OP_NONE;
      #1 chk("alu result", alu_result_o, sum[7:0]);
      rchk("flags", csp_pkg::IDX_STATUS, {5'h03, fl});
    end
    $display("test arithmetic flags done");
  endtask : t_alu

  task automatic t_events();
    // Pulses clear, sleep, timeout, then expected timeout and power flags
    logic [4:0] ev [7] = '{5'h0A, 5'h04, 5'h0E, 5'h04, 5'h1B, 5'h05, 5'h1F};
    logic [31:0] rd;
    logic err;
    wr(csp_pkg::IDX_STATUS, 8'h18);
    for (int k = 0; k < 7; k++) begin
      @(posedge ref_clk_i);
      {clrwdt_i, sleep_i, wdt_timeout_i} <= ev[k][4:2];
      @(posedge ref_clk_i);
      {clrwdt_i, sleep_i, wdt_timeout_i} <= 3'h0;
      apb(1'b0, csp_pkg::IDX_STATUS, 8'h00, rd, err);
      chk("power flags", rd[4:3], ev[k][1:0]);
    end
    $display("test power events done");
  endtask : t_events

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    do_reset(12);
    t_reset();
    t_regs();
    t_pointer();
    t_ports();
    t_alu();
    t_events();
    do_reset(2);
    t_reset();
    give_verdict();
  end
endmodule : csp_regs_test
